// [cdt_host.sv]
// Host controller driving an isolated CAN transceiver through its logic pins
`default_nettype none
`include "cdt_map.svh"

module cdt_host #(
	parameter int unsigned DOM_MAX_CYC = `CDT_DOM_MAX_CYC,
	parameter int unsigned PRESET_CYC = `CDT_PRESET_CYC,
	parameter int unsigned SETTLE_CYC = `CDT_SETTLE_CYC,
	parameter int unsigned CHECK_CYC = `CDT_CHECK_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	input wire cdt_pkg::cdt_cmd_s i_cmd,
	input wire logic i_rxd_pin,
	output logic o_txd_pin,
	output logic o_node_pwr_en,
	output var cdt_pkg::cdt_stat_s o_status
);
	import cdt_pkg::*;

	localparam int unsigned LIM_A = (DOM_MAX_CYC > SETTLE_CYC) ? DOM_MAX_CYC : SETTLE_CYC;
	localparam int unsigned LIM_B = (LIM_A > PRESET_CYC) ? LIM_A : PRESET_CYC;
	localparam int CNT_W = $clog2(((LIM_B > CHECK_CYC) ? LIM_B : CHECK_CYC) + 1);

	cdt_state_e state_reg;
	cdt_state_e state_next;
	logic txd_reg;
	logic txd_next;
	logic pwr_reg;
	logic pwr_next;
	logic up_dom_reg;
	logic up_dom_next;
	logic [CNT_W-1:0] wait_reg;
	logic [CNT_W-1:0] wait_next;
	logic [CNT_W-1:0] dom_cnt_reg;
	logic [CNT_W-1:0] dom_cnt_next;
	logic ok_reg;
	logic ok_next;
	logic ok_valid_reg;
	logic ok_valid_next;
	logic self_reg;
	logic self_next;
	logic dom_to_reg;
	logic dom_to_next;
	logic stuck_reg;
	logic stuck_next;
	logic rx_sync;

	function automatic logic at_count(input logic [CNT_W-1:0] cnt, input int unsigned lim);
		at_count = (cnt == CNT_W'(lim - 1));
	endfunction : at_count

	// ------------------------------------------------------------------------
	// Receive pin synchroniser
	// ------------------------------------------------------------------------
	cdt_sync #(
		.W(1),
		.RST_VAL(`CDT_RX_IDLE)
	) u_rx_sync (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_clk_en(i_clk_en),
		.i_async(i_rxd_pin),
		.o_sync(rx_sync)
	);

	// ------------------------------------------------------------------------
	// Power sequencer
	// ------------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		txd_next = txd_reg;
		pwr_next = pwr_reg;
		up_dom_next = up_dom_reg;
		wait_next = wait_reg;
		ok_next = ok_reg;
		ok_valid_next = ok_valid_reg;
		self_next = self_reg;
		if (i_clk_en) begin
			wait_next = wait_reg + CNT_W'(1);
			unique case (state_reg)
				ST_OFF: begin
					wait_next = '0;
					if (i_cmd.pwr_up) begin
						ok_valid_next = 1'b0;
						state_next = ST_CHECK;
					end
				end
				ST_CHECK: begin
					if (at_count(wait_reg, CHECK_CYC)) begin
						ok_next = rx_sync;
						ok_valid_next = 1'b1;
						wait_next = '0;
						pwr_next = 1'b1;
						state_next = ST_UP;
					end
				end
				ST_UP: begin
					if (at_count(wait_reg, SETTLE_CYC)) begin
						self_next = (rx_sync == !up_dom_reg);
						wait_next = '0;
						state_next = ST_RUN;
					end
				end
				ST_RUN: begin
					wait_next = '0;
					txd_next = i_cmd.tx_bit;
					if (i_cmd.pwr_down) begin
						up_dom_next = i_cmd.up_dominant;
						txd_next = !i_cmd.up_dominant;
						state_next = ST_PRESET;
					end
				end
				ST_PRESET: begin
					if (at_count(wait_reg, PRESET_CYC)) begin
						pwr_next = 1'b0;
						wait_next = '0;
						state_next = ST_OFF;
					end
				end
				default: begin
					txd_next = 1'b1;
					pwr_next = 1'b0;
					state_next = ST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			state_reg <= ST_OFF;
			txd_reg <= 1'b1;
			pwr_reg <= 1'b0;
			up_dom_reg <= 1'b0;
			wait_reg <= '0;
			ok_reg <= 1'b0;
			ok_valid_reg <= 1'b0;
			self_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			txd_reg <= txd_next;
			pwr_reg <= pwr_next;
			up_dom_reg <= up_dom_next;
			wait_reg <= wait_next;
			ok_reg <= ok_next;
			ok_valid_reg <= ok_valid_next;
			self_reg <= self_next;
		end
	end

	// ------------------------------------------------------------------------
	// Dominant duration watch
	// ------------------------------------------------------------------------
	always_comb begin
		dom_cnt_next = dom_cnt_reg;
		dom_to_next = dom_to_reg;
		stuck_next = stuck_reg;
		if (i_clk_en) begin
			if (txd_reg) begin
				dom_cnt_next = '0;
				if (!txd_next) begin
					dom_to_next = 1'b0;
					stuck_next = 1'b0;
				end
			end else if (!at_count(dom_cnt_reg, DOM_MAX_CYC + 1)) begin
				dom_cnt_next = dom_cnt_reg + CNT_W'(1);
			end
			if (!txd_reg && at_count(dom_cnt_reg, DOM_MAX_CYC)) begin
				dom_to_next = 1'b1;
				stuck_next = !rx_sync;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			dom_cnt_reg <= '0;
			dom_to_reg <= 1'b0;
			stuck_reg <= 1'b0;
		end else begin
			dom_cnt_reg <= dom_cnt_next;
			dom_to_reg <= dom_to_next;
			stuck_reg <= stuck_next;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign o_txd_pin = txd_reg;
	assign o_node_pwr_en = pwr_reg;
	assign o_status.node_on = pwr_reg;
	assign o_status.busy = (state_reg != ST_OFF) && (state_reg != ST_RUN);
	assign o_status.shut_ok = ok_reg;
	assign o_status.shut_ok_valid = ok_valid_reg;
	assign o_status.self_check_ok = self_reg;
	assign o_status.rx_bit = rx_sync;
	assign o_status.dom_timeout = dom_to_reg;
	assign o_status.rx_stuck = stuck_reg;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	// Edge follows command
	edge_follow_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_clk_en && state_reg == ST_RUN && !i_cmd.pwr_down) |=> o_txd_pin == $past(i_cmd.tx_bit))
		else $error("transmit pin did not follow command within one cycle");

	preset_low_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(state_reg == ST_PRESET && up_dom_reg) |-> !o_txd_pin)
		else $error("dominant preset not held low before power-down");

	cut_after_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		$fell(o_node_pwr_en) |-> $past(state_reg) == ST_PRESET && o_txd_pin == !up_dom_reg)
		else $error("node power cut without transmit preset");

	silent_up_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		($rose(o_node_pwr_en) && !up_dom_reg) |-> o_txd_pin)
		else $error("silent power-up with transmit low");

	check_first_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		$rose(o_node_pwr_en) |-> o_status.shut_ok_valid && $past(state_reg) == ST_CHECK)
		else $error("node power enabled before stored level was read");

	off_stable_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(state_reg == ST_OFF && $past(state_reg) == ST_OFF) |-> $stable(o_txd_pin))
		else $error("transmit pin moved while node is off");

	dom_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_clk_en && !o_txd_pin && dom_cnt_reg == CNT_W'(DOM_MAX_CYC - 1)) |=> o_status.dom_timeout)
		else $error("dominant timeout flag not raised at the limit");

endmodule : cdt_host

`default_nettype wire

// [cdt_host_test.sv]
// Self-checking bench for the transceiver host
`default_nettype none

module cdt_host_test;
	timeunit 1ns;
	timeprecision 1ps;
	import cdt_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic en = 1'h1;
	logic bus_dom = 1'h0;
	logic sup_ok = 1'h1;
	logic rxd;
	logic txd;
	logic pwr;
	cdt_cmd_s cmd = '0;
	cdt_stat_s st;
	int n_fail = 0;
	int checks_done = 0;

	always #25 clk = ~clk;

	cdt_host #(.DOM_MAX_CYC(40), .PRESET_CYC(8), .SETTLE_CYC(8), .CHECK_CYC(4)) cdt_host_inst (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(en), .i_cmd(cmd), .i_rxd_pin(rxd),
		.o_txd_pin(txd), .o_node_pwr_en(pwr), .o_status(st));

	cdt_xcvr_model #(.TMO_CYC(30)) cdt_xcvr_model_inst (
		.i_clk_sys(clk), .i_node_pwr(pwr), .i_txd(txd), .i_bus_dom(bus_dom),
		.i_bus_supply_ok(sup_ok), .o_rxd(rxd));

	task conclude;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude

	task cmp_bit(input logic act, input logic exp);
		checks_done++;
		if (act !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, act, exp);
		end
	endtask : cmp_bit

	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task set(input logic [3:0] c);
		@(posedge clk);
		cmd <= cdt_cmd_s'(c);
	endtask : set

	task wait_idle;
		int i;
		for (i = 0; i < 100 && st.busy !== 1'h0; i++) begin
			tick(1);
		end
		if (st.busy !== 1'h0) begin
			cmp_bit(st.busy, 1'h0);
			conclude();
		end
	endtask : wait_idle

	task t_reset;
		cmp_bit(txd, 1'h1);
		cmp_bit(pwr, 1'h0);
		cmp_bit(st.busy, 1'h0);
		cmp_bit(st.rx_bit, 1'h1);
		$display("reset test done");
	endtask : t_reset

	task t_up;
		set(4'h9);
		set(4'h1);
		tick(1);
		cmp_bit(st.busy, 1'h1);
		tick(2);
		cmp_bit(pwr, 1'h0);
		tick(1);
		cmp_bit(pwr, 1'h1);
		cmp_bit(st.shut_ok, 1'h1);
		cmp_bit(st.shut_ok_valid, 1'h1);
		wait_idle();
		cmp_bit(st.self_check_ok, 1'h1);
		cmp_bit(st.node_on, 1'h1);
		$display("power-up test done");
	endtask : t_up

	task t_timeout;
		set(4'h0);
		tick(2);
		cmp_bit(txd, 1'h0);
		tick(18);
		cmp_bit(st.rx_bit, 1'h0);
		cmp_bit(st.dom_timeout, 1'h0);
		tick(30);
		cmp_bit(st.dom_timeout, 1'h1);
		cmp_bit(st.rx_stuck, 1'h0);
		cmp_bit(st.rx_bit, 1'h1);
		set(4'h1);
		tick(3);
		cmp_bit(st.dom_timeout, 1'h1);
		set(4'h0);
		tick(6);
		cmp_bit(st.dom_timeout, 1'h0);
		cmp_bit(st.rx_bit, 1'h0);
		@(posedge clk);
		sup_ok <= 1'h0;
		tick(4);
		cmp_bit(st.rx_bit, 1'h1);
		@(posedge clk);
		sup_ok <= 1'h1;
		tick(4);
		cmp_bit(st.rx_bit, 1'h0);
		set(4'h1);
		tick(4);
		cmp_bit(st.rx_bit, 1'h1);
		@(posedge clk);
		bus_dom <= 1'h1;
		tick(4);
		cmp_bit(st.rx_bit, 1'h0);
		@(posedge clk);
		bus_dom <= 1'h0;
		tick(4);
		@(posedge clk);
		bus_dom <= 1'h1;
		set(4'h0);
		tick(45);
		cmp_bit(st.dom_timeout, 1'h1);
		cmp_bit(st.rx_stuck, 1'h1);
		@(posedge clk);
		bus_dom <= 1'h0;
		set(4'h1);
		tick(4);
		cmp_bit(st.rx_bit, 1'h1);
		cmp_bit(st.rx_stuck, 1'h1);
		$display("timeout test done");
	endtask : t_timeout

	task t_hold;
		@(posedge clk);
		en <= 1'h0;
		bus_dom <= 1'h1;
		cmd <= cdt_cmd_s'(4'h0);
		tick(4);
		cmp_bit(txd, 1'h1);
		cmp_bit(st.rx_bit, 1'h1);
		@(posedge clk);
		en <= 1'h1;
		tick(2);
		cmp_bit(txd, 1'h0);
		cmp_bit(st.rx_bit, 1'h0);
		set(4'h1);
		bus_dom <= 1'h0;
		tick(2);
		cmp_bit(txd, 1'h1);
		$display("clock enable test done");
	endtask : t_hold

	task t_down(input logic d);
		set(d ? 4'h7 : 4'h5);
		set(4'h1);
		tick(1);
		cmp_bit(txd, !d);
		wait_idle();
		cmp_bit(pwr, 1'h0);
		cmp_bit(txd, !d);
		set(4'h5);
		set(4'h1);
		tick(3);
		cmp_bit(st.busy, 1'h0);
		cmp_bit(txd, !d);
		$display("power-down test done");
	endtask : t_down

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		tick(1);
		t_reset();
		t_up();
		t_timeout();
		t_hold();
		t_down(1'h1);
		t_up();
		t_down(1'h0);
		t_up();
		conclude();
	end
endmodule : cdt_host_test

`default_nettype wire

// [cdt_map.svh]
// Timing figures and derived cycle counts for the isolated CAN transceiver host
`ifndef CDT_MAP_SVH
`define CDT_MAP_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define CDT_CLK_MHZ 20

// ----------------------------------------------------------------------------
// Times in microseconds
// ----------------------------------------------------------------------------
`define CDT_DOM_MIN_US 250
`define CDT_DOM_MAX_US 765
`define CDT_EDGE_MAX_US 1
`define CDT_PRESET_US 10
`define CDT_SETTLE_US 50

// ----------------------------------------------------------------------------
// Cycle counts and receive idle level
// ----------------------------------------------------------------------------
`define CDT_DOM_MAX_CYC (`CDT_DOM_MAX_US * `CDT_CLK_MHZ)
`define CDT_EDGE_MAX_CYC (`CDT_EDGE_MAX_US * `CDT_CLK_MHZ)
`define CDT_PRESET_CYC (`CDT_PRESET_US * `CDT_CLK_MHZ)
`define CDT_SETTLE_CYC (`CDT_SETTLE_US * `CDT_CLK_MHZ)
`define CDT_CHECK_CYC 4
`define CDT_RX_IDLE 1'h1

`endif

// [cdt_pkg.sv]
// Types shared by the isolated CAN transceiver host
`default_nettype none

package cdt_pkg;

	// ------------------------------------------------------------------------
	// Sequencer states, Gray along off, check, up, run, preset
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_CHECK = 3'h1,
		ST_UP = 3'h3,
		ST_RUN = 3'h2,
		ST_PRESET = 3'h6
	} cdt_state_e;

	// ------------------------------------------------------------------------
	// User command and status
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic pwr_up;
		logic pwr_down;
		logic up_dominant;
		logic tx_bit;
	} cdt_cmd_s;

	typedef struct packed {
		logic node_on;
		logic busy;
		logic shut_ok;
		logic shut_ok_valid;
		logic self_check_ok;
		logic rx_bit;
		logic dom_timeout;
		logic rx_stuck;
	} cdt_stat_s;

endpackage : cdt_pkg

`default_nettype wire

// [cdt_sync.sv]
// Two-flop synchroniser for pin inputs
`default_nettype none

module cdt_sync #(
	parameter int unsigned W = 1,
	parameter logic RST_VAL = 1'h1
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] sync_reg;
	logic [W-1:0] sync_next;

	// ------------------------------------------------------------------------
	// Next values
	// ------------------------------------------------------------------------
	always_comb begin
		meta_next = meta_reg;
		sync_next = sync_reg;
		if (i_clk_en) begin
			meta_next = i_async;
			sync_next = meta_reg;
		end
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			meta_reg <= {W{RST_VAL}};
			sync_reg <= {W{RST_VAL}};
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign o_sync = sync_reg;

endmodule : cdt_sync

`default_nettype wire

// [cdt_xcvr_model.sv]
// Behavioural model of the isolated CAN transceiver logic side
`default_nettype none

module cdt_xcvr_model #(
	parameter int TMO_CYC = 30
) (
	input wire logic i_clk_sys,
	input wire logic i_node_pwr,
	input wire logic i_txd,
	input wire logic i_bus_dom,
	input wire logic i_bus_supply_ok,
	output logic o_rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	logic txd_q = 1'h1;
	logic pwr_q = 1'h0;
	logic drv_on = 1'h0;
	logic nv_txd = 1'h1;
	logic nv_rx = 1'h1;
	int cnt = 0;

	always @(posedge i_clk_sys) begin
		txd_q <= i_txd;
		pwr_q <= i_node_pwr;
		if (!i_node_pwr) begin
			drv_on <= 1'h0;
			cnt <= 0;
			if (pwr_q) begin
				nv_txd <= i_txd;
				nv_rx <= 1'h1;
			end
		end else if (!pwr_q) begin
			drv_on <= !nv_txd;
			cnt <= 0;
		end else if (txd_q && !i_txd) begin
			drv_on <= 1'h1;
			cnt <= 0;
		end else if (!txd_q && i_txd) begin
			drv_on <= 1'h0;
			cnt <= 0;
		end else if (drv_on) begin
			cnt <= cnt + 1;
			if (cnt >= TMO_CYC - 1) begin
				drv_on <= 1'h0;
			end
		end
	end

	always_comb begin
		if (!i_node_pwr) begin
			o_rxd = nv_rx;
		end else if (!i_bus_supply_ok) begin
			o_rxd = 1'h1;
		end else begin
			o_rxd = !(drv_on || i_bus_dom);
		end
	end
endmodule : cdt_xcvr_model

`default_nettype wire
